// file: adc_sleep_conv.sv
`timescale 1ns/10ps
module adc_sleep_conv
   import adc_pkg::*;
#(
   parameter int PRESC_DIV = PRESC_DEF
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // register port
   input  wire logic [2:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wrStb,
   input  wire logic              rdStb,
   output logic      [7:0]        rdata,
   // cpu sleep controller
   input  wire logic              cpuSleep,
   input  wire sleep_mode_t       sleepMode,
   input  wire logic              convIrqAck,
   output logic                   convIrq,
   output logic                   irqOut,
   // analog core
   input  wire logic signed [11:0] sarCode,
   output logic                   analogPowerOn,
   output logic                   sampleHold,
   output logic      [3:0]        channelSel,
   output logic                   gainHigh,
   output logic                   swapInputs,
   output logic                   bipolarMode
);
   // ***********************
   // registers
   // ***********************
   conv_state_t        state_r;
   conv_cfg_t          cfg_r;
   logic               power_r, go_r, done_r, irqEn_r;
   logic               bip_r, swap_r, lj_r, first_r;
   logic [3:0]         chan_r;
   logic [9:0]         res_r;
   logic [NUM_EV-1:0]  stat_r, mask_r;
   logic               sleep_r;
   logic [15:0]        presc_r;
   logic [4:0]         tick_r;
   logic [9:0]         fmtOut;
   logic               sleepEdge, napMode, eligible, swGo;
   logic               startConv, adcTick, finish, wrA;
   logic [4:0]         convLen, holdAt;
   logic [NUM_EV-1:0]  evSet;

   assign wrA       = wrStb && addr == OFF_CTRL_A;
   assign sleepEdge = cpuSleep && !sleep_r;
   assign napMode   = sleepMode == SLP_IDLE || sleepMode == SLP_NOISE;
   assign eligible  = power_r && state_r == ST_IDLE && irqEn_r;
   assign swGo      = wrA && wdata[BIT_GO] && (wdata[BIT_POWER] || power_r);
   // only the sleep entry edge or a go write starts, so staying asleep never rearms
   assign startConv = (sleepEdge && napMode && eligible)
                    || (swGo && state_r == ST_IDLE);
   assign adcTick   = presc_r == 16'(PRESC_DIV - 1);
   assign convLen   = first_r ? CONV_FIRST : CONV_NORM;
   assign holdAt    = first_r ? HOLD_FIRST : HOLD_NORM;
   assign finish    = state_r == ST_CONV && adcTick && tick_r == convLen - 5'h01;
   assign evSet[EV_DONE]  = finish;
   assign evSet[EV_SLEEP] = startConv && cpuSleep;

   // ***********************
   // conversion sequencing
   // ***********************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sleep_r <= 1'b0;
      else
         sleep_r <= cpuSleep;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= ST_IDLE;
         presc_r <= 16'h0000;
         tick_r  <= 5'h00;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               presc_r <= 16'h0000;
               tick_r  <= 5'h00;
               if (startConv)
                  state_r <= ST_CONV;
            end
            ST_CONV:
            begin
               // power off aborts; a foreign wake does not
               if (!power_r || (wrA && !wdata[BIT_POWER]))
                  state_r <= ST_IDLE;
               else if (finish)
                  state_r <= ST_IDLE;
               presc_r <= adcTick ? 16'h0000 : presc_r + 16'h0001;
               if (adcTick)
                  tick_r <= tick_r + 5'h01;
            end
         endcase
      end
   end

   // mux and polarity settings are frozen for the whole conversion; swap follows the register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cfg_r <= '0;
      else if (startConv)
      begin
         cfg_r.diff     <= chan_r >= 4'h4 && chan_r <= 4'hB;
         cfg_r.bipolar  <= bip_r;
         cfg_r.gainHigh <= chan_r[0];
         cfg_r.channel  <= chan_r;
      end
   end

   adc_result_format u_fmt (
      .cfg    (cfg_r),
      .code   (sarCode),
      .result (fmtOut)
   );

   // ***********************
   // control registers
   // ***********************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         power_r <= 1'b0;
         irqEn_r <= 1'b0;
         first_r <= 1'b1;
         bip_r   <= 1'b0;
         swap_r  <= 1'b0;
         lj_r    <= 1'b0;
         chan_r  <= 4'h0;
         mask_r  <= '0;
      end
      else
      begin
         if (wrA)
         begin
            // sleep mode never clears power; software must do it
            power_r <= wdata[BIT_POWER];
            irqEn_r <= wdata[BIT_IRQEN];
            if (!wdata[BIT_POWER])
               first_r <= 1'b1;
         end
         if (finish)
            first_r <= 1'b0;
         if (wrStb && addr == OFF_CTRL_B)
         begin
            bip_r  <= wdata[BIT_BIP];
            swap_r <= wdata[BIT_SWAP];
         end
         if (wrStb && addr == OFF_MUX)
         begin
            lj_r   <= wdata[BIT_LJ];
            chan_r <= wdata[3:0];
         end
         if (wrStb && addr == OFF_IRQ_MASK)
            mask_r <= wdata[NUM_EV-1:0];
      end
   end

   // go reads one for any running conversion
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         go_r <= 1'b0;
      else if (startConv)
         go_r <= 1'b1;
      else if (finish || state_r == ST_IDLE)
         go_r <= 1'b0;
   end

   // result and flag land together; set beats clear
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         done_r <= 1'b0;
         res_r  <= RST_RESULT;
      end
      else if (finish)
      begin
         done_r <= 1'b1;
         res_r  <= fmtOut;
      end
      else if ((wrA && wdata[BIT_DONE]) || convIrqAck)
         done_r <= 1'b0;
   end

   // ***********************
   // interrupts
   // ***********************
   // one sticky bit per event; a set in the clearing cycle wins
   generate
      for (genvar i = 0; i < NUM_EV; i++)
      begin : g_stat
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               stat_r[i] <= 1'b0;
            else if (evSet[i])
               stat_r[i] <= 1'b1;
            else if (wrStb && addr == OFF_IRQ_STAT && wdata[i])
               stat_r[i] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         convIrq <= 1'b0;
         irqOut  <= 1'b0;
      end
      else
      begin
         // a raised request wakes the sleeping cpu
         convIrq <= (done_r || finish) && irqEn_r && !convIrqAck;
         irqOut  <= |(stat_r & mask_r);
      end
   end

   // ***********************
   // analog side and readback
   // ***********************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         analogPowerOn <= 1'b0;
         sampleHold    <= 1'b0;
         channelSel    <= 4'h0;
         gainHigh      <= 1'b0;
         swapInputs    <= 1'b0;
         bipolarMode   <= 1'b0;
      end
      else
      begin
         analogPowerOn <= power_r;
         sampleHold    <= state_r == ST_CONV && adcTick && tick_r == holdAt;
         channelSel    <= state_r == ST_CONV ? cfg_r.channel : chan_r;
         gainHigh      <= state_r == ST_CONV ? cfg_r.gainHigh : chan_r[0];
         swapInputs    <= swap_r;
         bipolarMode   <= state_r == ST_CONV ? cfg_r.bipolar : bip_r;
      end
   end

   // justification is applied at read time, so it acts at once
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata <= RST_BYTE;
      else if (!rdStb)
         rdata <= RST_BYTE;
      else
         unique case (addr)
            OFF_CTRL_A:   rdata <= {power_r, go_r, 1'b0, done_r, irqEn_r, 3'h0};
            OFF_CTRL_B:   rdata <= {bip_r, 1'b0, swap_r, 5'h00};
            OFF_MUX:      rdata <= {2'h0, lj_r, 1'b0, chan_r};
            OFF_RES_LOW:  rdata <= lj_r ? {res_r[1:0], 6'h00} : res_r[7:0];
            OFF_RES_HIGH: rdata <= lj_r ? res_r[9:2] : {6'h00, res_r[9:8]};
            OFF_IRQ_STAT: rdata <= {6'h00, stat_r};
            OFF_IRQ_MASK: rdata <= {6'h00, mask_r};
            default:      rdata <= RST_BYTE;
         endcase
   end

   // ***********************
   // assertions
   // ***********************
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   a_sleep_start_conv: assert property (
      sleepEdge && napMode && eligible |=> state_r == ST_CONV && go_r)
      else $error("sleep entry did not start a conversion");
   a_sleep_status_set: assert property (
      sleepEdge && napMode && eligible |=> stat_r[EV_SLEEP])
      else $error("sleep start not flagged");
   a_go_while_busy: assert property (
      state_r == ST_CONV |-> go_r)
      else $error("go reads zero during conversion");
   a_other_sleep_idle: assert property (
      sleepEdge && sleepMode == SLP_OTHER && !wrA && state_r == ST_IDLE
      |=> state_r == ST_IDLE && power_r == $past(power_r)
      ##1 analogPowerOn == $past(power_r, 2))
      else $error("other sleep mode misbehaved");
   a_no_rearm_idle: assert property (
      state_r == ST_IDLE && !sleepEdge && !swGo |=> state_r == ST_IDLE)
      else $error("conversion started without sleep entry or go");
   a_done_wakes_cpu: assert property (
      finish && irqEn_r && !convIrqAck |=> convIrq && done_r)
      else $error("completion did not raise interrupt");
   a_finish_go_clear: assert property (
      finish |=> done_r && !go_r && state_r == ST_IDLE)
      else $error("completion flags wrong");
   a_result_with_flag: assert property (
      finish |=> res_r == $past(fmtOut))
      else $error("result not written with flag");
   a_bip_latched: assert property (
      startConv ##1 cfg_r.bipolar |-> $past(bip_r))
      else $error("bipolar used without select");
   a_uni_saturate: assert property (
      !cfg_r.bipolar && sarCode < 12'sh000 |-> fmtOut == 10'h000)
      else $error("negative unipolar not saturated");
   a_bip_sign_bit: assert property (
      cfg_r.diff && cfg_r.bipolar |-> fmtOut[9] == sarCode[11])
      else $error("bipolar sign bit wrong");
   a_left_justify: assert property (
      rdStb && addr == OFF_RES_HIGH && lj_r && !finish |=> rdata == res_r[9:2])
      else $error("left justified read wrong");
   a_right_justify: assert property (
      rdStb && addr == OFF_RES_LOW && !lj_r && !finish |=> rdata == res_r[7:0])
      else $error("right justified read wrong");

   c_sleep_conv: cover property (sleepEdge && napMode && eligible ##[1:1000] finish);
   c_bip_neg: cover property (finish && cfg_r.bipolar && fmtOut[9]);
   c_other_sleep: cover property (sleepEdge && sleepMode == SLP_OTHER && power_r);
   c_foreign_wake: cover property (state_r == ST_CONV && $fell(cpuSleep));
endmodule

// file: adc_pkg.sv
package adc_pkg;
   // ***********************
   // register indices
   // ***********************
   localparam logic [2:0] OFF_CTRL_A   = 3'h0;
   localparam logic [2:0] OFF_CTRL_B   = 3'h1;
   localparam logic [2:0] OFF_MUX      = 3'h2;
   localparam logic [2:0] OFF_RES_LOW  = 3'h3;
   localparam logic [2:0] OFF_RES_HIGH = 3'h4;
   localparam logic [2:0] OFF_IRQ_STAT = 3'h5;
   localparam logic [2:0] OFF_IRQ_MASK = 3'h6;
   // ***********************
   // field positions
   // ***********************
   localparam int BIT_POWER  = 7;
   localparam int BIT_GO     = 6;
   localparam int BIT_DONE   = 4;
   localparam int BIT_IRQEN  = 3;
   localparam int BIT_BIP    = 7;
   localparam int BIT_SWAP   = 5;
   localparam int BIT_LJ     = 5;
   localparam int EV_DONE    = 0;
   localparam int EV_SLEEP   = 1;
   localparam int NUM_EV     = 2;
   // ***********************
   // reset values and counts
   // ***********************
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [9:0] RST_RESULT = 10'h000;
   localparam logic [4:0] CONV_NORM  = 5'h0D;
   localparam logic [4:0] CONV_FIRST = 5'h19;
   localparam logic [4:0] HOLD_NORM  = 5'h01;
   localparam logic [4:0] HOLD_FIRST = 5'h0D;
   localparam int         PRESC_DEF  = 8;
   localparam logic signed [11:0] UNI_MAX = 12'sh3FF;
   localparam logic signed [11:0] BIP_MAX = 12'sh1FF;
   localparam logic signed [11:0] BIP_MIN = -12'sh200;

   typedef enum logic [1:0] {
      SLP_IDLE  = 2'h0,
      SLP_NOISE = 2'h1,
      SLP_OTHER = 2'h2
   } sleep_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } conv_state_t;

   // settings latched at conversion start
   typedef struct packed {
      logic       diff;
      logic       bipolar;
      logic       gainHigh;
      logic [3:0] channel;
   } conv_cfg_t;
endpackage

// file: adc_result_format.sv
`timescale 1ns/10ps
module adc_result_format
   import adc_pkg::*;
(
   // mode and raw code
   input  wire conv_cfg_t          cfg,
   input  wire logic signed [11:0] code,
   // formatted 10-bit result
   output logic             [9:0]  result
);
   logic signed [11:0] half;

   always_comb
   begin
      half = code >>> 1;
      if (cfg.diff && cfg.bipolar)
      begin
         // two's complement, sign lands in bit 9
         if (half > BIP_MAX)
            result = BIP_MAX[9:0];
         else if (half < BIP_MIN)
            result = BIP_MIN[9:0];
         else
            result = half[9:0];
      end
      else if (code < 12'sh000)
         result = 10'h000;
      else if (code > UNI_MAX)
         result = UNI_MAX[9:0];
      else
         result = code[9:0];
   end
endmodule

// file: adc_cpu_model.sv
`timescale 1ns/10ps
module adc_cpu_model
   import adc_pkg::*;
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rstn,
   // bench commands
   input  wire logic               goSleep,
   input  wire sleep_mode_t        mode,
   input  wire logic               wakeOther,
   input  wire logic signed [11:0] rawCode,
   // converter side
   input  wire logic               convIrq,
   output logic                    cpuSleep,
   output sleep_mode_t             sleepMode,
   output logic                    convIrqAck,
   output logic signed [11:0]      sarCode
);
   // ***********************
   // analog core stand-in
   // ***********************
   logic [1:0] ackGap_r;
   assign sarCode = rawCode;
   // ***********************
   // sleep controller
   // ***********************
   // once awake the cpu stays awake until the bench orders a new sleep
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cpuSleep  <= 1'b0;
         sleepMode <= SLP_IDLE;
      end
      else if (goSleep)
      begin
         cpuSleep  <= 1'b1;
         sleepMode <= mode;
      end
      else if (cpuSleep && (convIrq || wakeOther))
         cpuSleep <= 1'b0;
   end
   // vector taken once; the gap covers the lag of convIrq behind the flag
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         convIrqAck <= 1'b0;
         ackGap_r   <= 2'h0;
      end
      else if (convIrq && !cpuSleep && ackGap_r == 2'h0)
      begin
         convIrqAck <= 1'b1;
         ackGap_r   <= 2'h3;
      end
      else
      begin
         convIrqAck <= 1'b0;
         if (ackGap_r != 2'h0)
            ackGap_r <= ackGap_r - 2'h1;
      end
   end
endmodule

// file: test_adc_sleep_conv.sv
`timescale 1ns/10ps
module test_adc_sleep_conv;
   import adc_pkg::*;
   // ***********************
   // signals
   // ***********************
   logic               clk, rstn, wrStb, rdStb, goSleep, wakeOther;
   logic [2:0]         addr;
   logic [7:0]         wdata, rdata, v;
   logic [15:0]        r;
   sleep_mode_t        mode, sleepMode;
   logic signed [11:0] rawCode, sarCode;
   logic               cpuSleep, convIrqAck, convIrq, irqOut, analogPowerOn;
   logic               gainHigh, swapInputs, bipolarMode, sampleHold;
   logic [3:0]         channelSel;
   int                 errCount, nCompared, nHold;
   // result table: channel, bipolar, raw code, expected code
   logic [3:0]  tCh [6] = '{4'h0, 4'h6, 4'h7, 4'h6, 4'h6, 4'h6};
   logic        tBip[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   logic [11:0] tRaw[6] = '{12'h7FF, 12'hFFB, 12'h3FF, 12'hC00, 12'h3FE, 12'hFFE};
   logic [9:0]  tExp[6] = '{10'h3FF, 10'h000, 10'h3FF, 10'h200, 10'h1FF, 10'h3FF};
   always #4 clk = ~clk;
   // one hold pulse is expected for every conversion that gets that far
   always @(posedge clk)
      if (sampleHold === 1'b1)
         nHold <= nHold + 1;
   adc_sleep_conv #(.PRESC_DIV(1)) adc_sleep_conv_i (
      .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wrStb(wrStb),
      .rdStb(rdStb), .rdata(rdata), .cpuSleep(cpuSleep), .sleepMode(sleepMode),
      .convIrqAck(convIrqAck), .convIrq(convIrq), .irqOut(irqOut), .sarCode(sarCode),
      .analogPowerOn(analogPowerOn), .sampleHold(sampleHold), .channelSel(channelSel),
      .gainHigh(gainHigh), .swapInputs(swapInputs), .bipolarMode(bipolarMode));
   adc_cpu_model adc_cpu_model_i (
      .clk(clk), .rstn(rstn), .goSleep(goSleep), .mode(mode), .wakeOther(wakeOther),
      .rawCode(rawCode), .convIrq(convIrq), .cpuSleep(cpuSleep),
      .sleepMode(sleepMode), .convIrqAck(convIrqAck), .sarCode(sarCode));
   // ***********************
   // tasks
   // ***********************
   task automatic give_verdict;
      if (errCount == 0 && nCompared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic pulse(input logic sl, input sleep_mode_t m);
      @(posedge clk);
      goSleep   <= sl;
      wakeOther <= !sl;
      mode      <= m;
      @(posedge clk);
      goSleep   <= 1'b0;
      wakeOther <= 1'b0;
   endtask
   task automatic waitIrq;
      for (int i = 0; i < 100 && convIrq !== 1'b1; i++)
         step(1);
      if (convIrq !== 1'b1)
      begin
         errCount++;
         give_verdict();
      end
   endtask
   task automatic waitDone;
      v = 8'h00;
      for (int i = 0; i < 60 && v[BIT_DONE] !== 1'b1; i++)
         rd(OFF_CTRL_A, v);
      if (v[BIT_DONE] !== 1'b1)
      begin
         errCount++;
         give_verdict();
      end
   endtask
   task automatic rdRes;
      rd(OFF_RES_LOW, r[7:0]);
      rd(OFF_RES_HIGH, r[15:8]);
   endtask
   // ***********************
   // sequence
   // ***********************
   initial
   begin
      clk = 1'b0; rstn = 1'b0; addr = 3'h0; wdata = 8'h00; wrStb = 1'b0; rdStb = 1'b0;
      goSleep = 1'b0; mode = SLP_IDLE; wakeOther = 1'b0; rawCode = 12'sh155;
      errCount = 0; nCompared = 0;
      nHold = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 0; a < 8; a++)
      begin
         rd(a[2:0], v);
         chk("reset value", {8'h00, v}, 16'h0000);
      end
      chk("outputs at reset", {13'h0000, irqOut, convIrq, analogPowerOn}, 16'h0000);
      // noise canceler, woken by completion
      wr(OFF_MUX, 8'h00);
      wr(OFF_CTRL_A, 8'h88);
      pulse(1'b1, SLP_NOISE);
      waitIrq();
      step(2);
      chk("cpu awake", {15'h0000, cpuSleep}, 16'h0000);
      rdRes();
      chk("sleep result", r, 16'h0155);
      rd(OFF_IRQ_STAT, v);
      chk("status", {8'h00, v}, 16'h0003);
      chk("irq masked", {15'h0000, irqOut}, 16'h0000);
      wr(OFF_IRQ_MASK, 8'h01);
      step(2);
      chk("irq unmasked", {15'h0000, irqOut}, 16'h0001);
      wr(OFF_IRQ_STAT, 8'h03);
      step(2);
      chk("irq cleared", {15'h0000, irqOut}, 16'h0000);
      rd(OFF_IRQ_STAT, v);
      chk("status cleared", {8'h00, v}, 16'h0000);
      wr(OFF_MUX, 8'h20);
      rdRes();
      chk("left justified", r, 16'h5540);
      wr(OFF_MUX, 8'h00);
      // another interrupt wakes the cpu first
      rawCode <= 12'sh0AA;
      pulse(1'b1, SLP_IDLE);
      step(3);
      pulse(1'b0, SLP_IDLE);
      step(1);
      chk("early wake", {15'h0000, cpuSleep}, 16'h0000);
      rd(OFF_CTRL_A, v);
      chk("still converting", {8'h00, v}, 16'h00C8);
      waitIrq();
      rd(OFF_RES_LOW, v);
      chk("late result", {8'h00, v}, 16'h00AA);
      step(40);
      rd(OFF_CTRL_A, v);
      chk("stays idle", {8'h00, v}, 16'h0088);
      // deeper sleep: no conversion, converter stays powered
      pulse(1'b1, SLP_OTHER);
      step(40);
      chk("other sleep", {14'h0000, analogPowerOn, convIrq}, 16'h0002);
      rd(OFF_CTRL_A, v);
      chk("no start", {8'h00, v}, 16'h0088);
      pulse(1'b0, SLP_IDLE);
      // result coding across modes
      for (int k = 0; k < 6; k++)
      begin
         wr(OFF_MUX, {4'h0, tCh[k]});
         wr(OFF_CTRL_B, {tBip[k], 7'h00});
         rawCode <= tRaw[k];
         wr(OFF_CTRL_A, 8'hC0);
         waitDone();
         chk("finish flags", {8'h00, v}, 16'h0090);
         rdRes();
         chk("coded result", r, {6'h00, tExp[k]});
         chk("mode pins", {10'h000, gainHigh, bipolarMode, channelSel},
             {10'h000, tCh[k][0], tBip[k], tCh[k]});
         wr(OFF_CTRL_A, 8'h90);
      end
      // two sleep conversions and six register started ones so far
      chk("hold pulses", nHold[15:0], 16'h0008);
      // negative sign seen: select swapped inputs for the next conversion
      if (r[9])
         wr(OFF_CTRL_B, 8'h20);
      step(2);
      chk("swap pin", {15'h0000, swapInputs}, 16'h0001);
      // power off cuts a running conversion short, no done flag follows
      wr(OFF_CTRL_A, 8'hC0);
      wr(OFF_CTRL_A, 8'h00);
      step(30);
      rd(OFF_CTRL_A, v);
      chk("cut conversion", {8'h00, v}, 16'h0000);
      chk("power pin off", {15'h0000, analogPowerOn}, 16'h0000);
      give_verdict();
   end
endmodule
